// ---- bench/mii_phy_model.sv ----
`timescale 1ns/100ps

module mii_phy_model
(
   // Clocks handed to the port
   output logic txClk,
   output logic rxClk,
   // Transmit side from the port
   input wire logic [3:0] txNibble,
   input wire logic txValid,
   // Receive side toward the port
   output logic [3:0] rxNibble = 4'h0,
   output logic rxValid = 1'b0,
   output logic col,
   output logic crs = 1'b0
);
   logic [3:0] txQ[$];
   logic colOn = 1'b0;
   logic rxBusy = 1'b0;
   wire crsReq = txValid === 1'b1 || rxBusy || colOn;

   // Free-running link clocks, phase unrelated to the system clock
   initial txClk = 1'b0;
   always #62.5 txClk = ~txClk;
   initial
   begin
      rxClk = 1'b0;
      #41;
      forever #62.5 rxClk = ~rxClk;
   end

   // Record every nibble presented while the frame strobe is up
   always @(posedge txClk)
      if (txValid === 1'b1)
         txQ.push_back(txNibble);

   // Carrier rises at once but only falls on a receive edge
   always @(posedge rxClk or posedge crsReq)
      crs <= crsReq;

   assign col = colOn;

   // Idle data keeps changing so a stale nibble can never pass for a good one
   always @(negedge rxClk)
      if (!rxBusy)
         rxNibble <= ~rxNibble;

   task automatic rxFrame(input logic [3:0] q[$]);
      @(posedge rxClk);
      rxBusy = 1'b1;
      foreach (q[i])
      begin
         @(negedge rxClk);
         rxNibble <= q[i];
         rxValid <= 1'b1;
      end
      @(negedge rxClk);
      rxValid <= 1'b0;
      rxBusy = 1'b0;
   endtask

   task automatic collide(input int n);
      #13 colOn = 1'b1; // Raised off any edge
      repeat (n) @(posedge rxClk);
      colOn = 1'b0;
   endtask
endmodule

// ---- bench/mii_port_checker.sv ----
`timescale 1ns/100ps
`include "mii_port_consts.svh"

module mii_port_checker
(
   // System side
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rxNibbleValid,
   input wire logic carrierSense,
   input wire logic collision,
   input wire logic portEnabled,
   // Link side
   input wire logic port_c_transmit_clock,
   input wire logic [3:0] port_c_transmit_nibble,
   input wire logic port_c_transmit_valid,
   input wire logic port_c_collision,
   input wire logic port_c_carrier_sense
);
   logic [2:0] upCnt_reg;
   logic [2:0] upCnt_next;

   // Edges since reset release, saturating; a late enable means the fuse was sampled again
   always_comb
   begin
      upCnt_next = (upCnt_reg == 3'h7) ? upCnt_reg : upCnt_reg + 3'h1;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         upCnt_reg <= 3'h0;
      else
         upCnt_reg <= upCnt_next;
   end

   property p_tx_idle;
      @(posedge port_c_transmit_clock) disable iff (!rst_n)
      !port_c_transmit_valid |-> port_c_transmit_nibble == `MII_TX_IDLE;
   endproperty
   a_tx_idle: assert property (p_tx_idle) else $error("Nibble not idle");
   property p_tx_pre;
      @(posedge port_c_transmit_clock) disable iff (!rst_n) $rose(port_c_transmit_valid)
      |-> (port_c_transmit_valid && port_c_transmit_nibble == `MII_PREAMBLE_NIBBLE)[*8];
   endproperty
   a_tx_pre: assert property (p_tx_pre) else $error("Frame start wrong");
   property p_tx_sfd;
      @(posedge port_c_transmit_clock) disable iff (!rst_n)
      $rose(port_c_transmit_valid) |-> ##15 port_c_transmit_nibble == `MII_SFD_NIBBLE;
   endproperty
   a_tx_sfd: assert property (p_tx_sfd) else $error("Delimiter misplaced");
   property p_rx_gate;
      @(posedge clk) disable iff (!rst_n) rxNibbleValid |-> portEnabled;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("Nibble while disabled");
   property p_fuse_once;
      @(posedge clk) disable iff (!rst_n) $rose(portEnabled) |-> upCnt_reg < 3'h4;
   endproperty
   a_fuse_once: assert property (p_fuse_once) else $error("Late enable");
   property p_fuse_keep;
      @(posedge clk) disable iff (!rst_n) portEnabled |=> portEnabled;
   endproperty
   a_fuse_keep: assert property (p_fuse_keep) else $error("Enable dropped");
   property p_crs_sync;
      @(posedge clk) disable iff (!rst_n) (portEnabled && port_c_carrier_sense)[*5] |-> carrierSense;
   endproperty
   a_crs_sync: assert property (p_crs_sync) else $error("Carrier not seen");
   property p_col_sync;
      @(posedge clk) disable iff (!rst_n) (portEnabled && port_c_collision)[*5] |-> collision;
   endproperty
   a_col_sync: assert property (p_col_sync) else $error("Collision not seen");
   property p_col_drop;
      @(posedge clk) disable iff (!rst_n) (!port_c_collision)[*5] |-> !collision;
   endproperty
   a_col_drop: assert property (p_col_drop) else $error("Collision stuck");
endmodule

bind mii_port_signalling mii_port_checker CHK
(
   .clk, .rst_n, .rxNibbleValid, .carrierSense, .collision, .portEnabled, .port_c_transmit_clock,
   .port_c_transmit_nibble, .port_c_transmit_valid, .port_c_collision, .port_c_carrier_sense
);

// ---- bench/tb_top.sv ----
`timescale 1ns/100ps
`include "mii_port_consts.svh"

module tb_top;
   typedef struct {int n; logic last; logic [7:0] b[4]; int nib;} row_s;
   localparam int MaxBytes = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic fuseEnable = 1'b1;
   logic txLoadValid = 1'b0;
   logic [7:0] txLoadByte = 8'h00;
   logic txLoadLast = 1'b0;
   logic txLoadReady, txDone, rxNibbleValid, rxFrameEnd, carrierSense, collision, portEnabled;
   logic [3:0] rxNibble, txNib, rxNib;
   logic txClk, rxClk, txVal, rxVal, colLine, crsLine;
   logic [3:0] rxGot[$];
   logic [3:0] rxExp[6] = '{4'h5, 4'hD, 4'h1, 4'hE, 4'h7, 4'h8};
   int rxEnds = 0;
   int errors = 0;
   int cmp_count = 0;
   // Bytes, end marker, expected nibbles; the last row ends on the size limit alone
   row_s rows[3] = '{'{1, 1'b1, '{8'hA5, 8'h00, 8'h00, 8'h00}, 18},
      '{2, 1'b1, '{8'h3C, 8'hF0, 8'h00, 8'h00}, 20}, '{4, 1'b0, '{8'h12, 8'h34, 8'h56, 8'h78}, 24}};

   always #10 clk = ~clk;

   mii_port_signalling #(.MaxBytes(MaxBytes)) DUT
   (
      .clk(clk), .rst_n(rst_n), .fuseEnable(fuseEnable), .txLoadValid(txLoadValid), .txLoadByte(txLoadByte),
      .txLoadLast(txLoadLast), .txLoadReady(txLoadReady), .txDone(txDone), .rxNibbleValid(rxNibbleValid),
      .rxNibble(rxNibble), .rxFrameEnd(rxFrameEnd), .carrierSense(carrierSense), .collision(collision),
      .portEnabled(portEnabled), .port_c_transmit_clock(txClk), .port_c_transmit_nibble(txNib),
      .port_c_transmit_valid(txVal), .port_c_receive_clock(rxClk), .port_c_receive_nibble(rxNib),
      .port_c_receive_valid(rxVal), .port_c_collision(colLine), .port_c_carrier_sense(crsLine)
   );

   mii_phy_model PHY
   (
      .txClk(txClk), .rxClk(rxClk), .txNibble(txNib), .txValid(txVal), .rxNibble(rxNib),
      .rxValid(rxVal), .col(colLine), .crs(crsLine)
   );

   // Gather what the port hands over on the system side
   always @(negedge clk)
   begin
      if (rxNibbleValid === 1'b1)
         rxGot.push_back(rxNibble);
      if (rxFrameEnd === 1'b1)
         rxEnds++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [3:0] expNib(input row_s r, input int k);
      if (k < 15)
         return `MII_PREAMBLE_NIBBLE;
      if (k == 15)
         return `MII_SFD_NIBBLE;
      return k % 2 == 0 ? r.b[(k - 16) / 2][3:0] : r.b[(k - 16) / 2][7:4];
   endfunction

   // Load bytes back to back, wait for the frame to leave, then compare the link nibbles
   task automatic sendFrame(input row_s r);
      int w;
      for (int i = 0; i < r.n; i++)
      begin
         @(negedge clk);
         w = 0;
         while (txLoadReady !== 1'b1 && w < 100)
         begin
            @(negedge clk);
            w++;
         end
         txLoadValid = 1'b1;
         txLoadByte = r.b[i];
         txLoadLast = r.last && (i == r.n - 1);
      end
      @(negedge clk);
      txLoadValid = 1'b0;
      txLoadLast = 1'b0;
      w = 0;
      while (txDone !== 1'b1 && w < 3000)
      begin
         @(negedge clk);
         w++;
      end
      check(32'(PHY.txQ.size()), 32'(r.nib));
      foreach (PHY.txQ[k])
         check(32'(PHY.txQ[k]), 32'(expNib(r, k)));
      PHY.txQ.delete();
   endtask

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   initial
   begin
      // Every flop except the frame store resets asynchronously, so eight cycles suffice for all domains
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check(32'(portEnabled), 32'h1);
      foreach (rows[i])
      begin
         sendFrame(rows[i]);
         $display("Test transmit row %0d done", i);
      end
      PHY.rxFrame('{4'h5, 4'hD, 4'h1, 4'hE});
      PHY.rxFrame('{4'h7, 4'h8});
      repeat (20) @(negedge clk);
      check(32'(rxGot.size()), 32'h6);
      foreach (rxExp[i])
         check(32'(rxGot[i]), 32'(rxExp[i]));
      check(32'(rxEnds), 32'h2);
      $display("Test receive done");
      fork
         PHY.collide(12);
      join_none
      repeat (40) @(negedge clk);
      check(32'(collision), 32'h1);
      check(32'(carrierSense), 32'h1);
      repeat (80) @(negedge clk);
      check(32'(collision), 32'h0);
      check(32'(carrierSense), 32'h0);
      $display("Test collision done");
      fuseEnable = 1'b0;
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      fuseEnable = 1'b1;
      repeat (8) @(negedge clk);
      check(32'(portEnabled), 32'h0);
      check(32'(txLoadReady), 32'h0);
      rxGot.delete();
      PHY.rxFrame('{4'h3, 4'h4});
      repeat (20) @(negedge clk);
      check(32'(rxGot.size()), 32'h0);
      $display("Test fuse disable done");
      results();
   end

   // Whole sequence needs about fifteen microseconds; this leaves wide margin
   initial
   begin
      #400000;
      errors++;
      results();
   end
endmodule

// ---- hw/mii_port_consts.svh ----
`ifndef MII_PORT_CONSTS_SVH
`define MII_PORT_CONSTS_SVH

// Nibble width on both directions of the link
`define MII_NIBBLE_W 4
// Idle value presented on the transmit nibble bus
`define MII_TX_IDLE 4'h0
// Preamble and start-of-frame nibbles
`define MII_PREAMBLE_NIBBLE 4'h5
`define MII_SFD_NIBBLE 4'hD
// Preamble nibble count before the delimiter nibble
`define MII_PREAMBLE_COUNT 15
// Default depth of one frame, in bytes, held for transmit
`define MII_TX_MAX_BYTES 64
// Synchroniser stage count
`define MII_SYNC_STAGES 2

`endif

// ---- hw/mii_port_pkg.sv ----
package mii_port_pkg;

   // Transmit side sequence
   typedef enum logic [1:0] {TX_IDLE, TX_PREAMBLE, TX_DATA} tx_state_e;

   // Nibble value
   typedef logic [3:0] nibble_t;

endpackage

// ---- hw/mii_port_signalling.sv ----
`timescale 1ns/100ps
`include "mii_port_consts.svh"

// Operation
// - Drive transmit nibble on transmit clock
// - Transmit valid from preamble to last nibble
// - Sample receive nibble on receive clock
// - Accept receive nibbles only while valid
// - Fuse gate latched at boot, sticky disable
module mii_port_signalling
#(
   parameter int MaxBytes = `MII_TX_MAX_BYTES
)
(
   // System clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Boot-time fuse gate, high enables the port
   input wire logic fuseEnable,
   // Frame to send, loaded in the system domain
   input wire logic txLoadValid,
   input wire logic [7:0] txLoadByte,
   input wire logic txLoadLast,
   output logic txLoadReady,
   output logic txDone,
   // Received nibble stream in the system domain
   output logic rxNibbleValid,
   output logic [3:0] rxNibble,
   output logic rxFrameEnd,
   // Status in the system domain
   output logic carrierSense,
   output logic collision,
   output logic portEnabled,
   // Transmit link
   input wire logic port_c_transmit_clock,
   output logic [3:0] port_c_transmit_nibble,
   output logic port_c_transmit_valid,
   // Receive link
   input wire logic port_c_receive_clock,
   input wire logic [3:0] port_c_receive_nibble,
   input wire logic port_c_receive_valid,
   input wire logic port_c_collision,
   input wire logic port_c_carrier_sense
);

   localparam int AddrW = $clog2(MaxBytes);

   initial
   begin
      if (MaxBytes < 2 || MaxBytes > 4096)
         $error("MaxBytes out of range");
   end

   // ---------------- System domain: fuse gate and frame store
   logic bootDone_reg, bootDone_next;
   logic enable_reg, enable_next;
   logic [7:0] mem_reg [MaxBytes];
   logic [AddrW-1:0] wrPtr_reg, wrPtr_next;
   logic [AddrW-1:0] len_reg, len_next;
   logic busy_reg, busy_next;
   logic start_reg, start_next;
   logic txDone_reg, txDone_next;
   logic ready_reg, ready_next;
   logic txEndSys;
   logic rxPulseSys;
   logic rxEndSys;
   logic crsSync, colSync;
   logic crs_reg, col_reg;

   // Fuse sampled once after reset release; a disable stays until reset
   always_comb
   begin
      bootDone_next = 1'b1;
      enable_next = enable_reg;
      if (!bootDone_reg)
         enable_next = fuseEnable;
   end

   // Frame loading; storage is frozen while the link side reads it
   always_comb
   begin
      wrPtr_next = wrPtr_reg;
      len_next = len_reg;
      busy_next = busy_reg;
      start_next = 1'b0;
      txDone_next = 1'b0;
      if (txEndSys)
      begin
         busy_next = 1'b0;
         txDone_next = 1'b1;
      end
      else if (!busy_reg && txLoadValid && enable_reg && bootDone_reg)
      begin
         if (txLoadLast || wrPtr_reg == AddrW'(MaxBytes - 1))
         begin
            len_next = wrPtr_reg;
            wrPtr_next = '0;
            busy_next = 1'b1;
            start_next = 1'b1;
         end
         else
            wrPtr_next = wrPtr_reg + 1'b1;
      end
      // Registered so the ready output comes straight from a flip-flop
      ready_next = enable_next & ~busy_next;
   end

   always_ff @(posedge clk)
   begin
      if (!busy_reg && txLoadValid && enable_reg && bootDone_reg)
         mem_reg[wrPtr_reg] <= txLoadByte;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bootDone_reg <= 1'b0;
         enable_reg <= 1'b0;
         wrPtr_reg <= '0;
         len_reg <= '0;
         busy_reg <= 1'b0;
         start_reg <= 1'b0;
         txDone_reg <= 1'b0;
         ready_reg <= 1'b0;
         crs_reg <= 1'b0;
         col_reg <= 1'b0;
      end
      else
      begin
         bootDone_reg <= bootDone_next;
         enable_reg <= enable_next;
         wrPtr_reg <= wrPtr_next;
         len_reg <= len_next;
         busy_reg <= busy_next;
         start_reg <= start_next;
         txDone_reg <= txDone_next;
         ready_reg <= ready_next;
         crs_reg <= crsSync & enable_reg;
         col_reg <= colSync & enable_reg;
      end
   end

   // Carrier sense and collision are asynchronous levels
   mii_sync_bit crsSyncer
   (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(port_c_carrier_sense),
      .syncOut(crsSync)
   );

   mii_sync_bit colSyncer
   (
      .clk(clk),
      .rst_n(rst_n),
      .asyncIn(port_c_collision),
      .syncOut(colSync)
   );

   // Enable level into each link domain
   logic txEnable, rxEnable;
   logic txStart;

   mii_sync_bit txEnSync
   (
      .clk(port_c_transmit_clock),
      .rst_n(rst_n),
      .asyncIn(enable_reg),
      .syncOut(txEnable)
   );

   mii_sync_bit rxEnSync
   (
      .clk(port_c_receive_clock),
      .rst_n(rst_n),
      .asyncIn(enable_reg),
      .syncOut(rxEnable)
   );

   // ---------------- Transmit link domain
   mii_toggle_sync startXfer
   (
      .srcClk(clk),
      .srcRst_n(rst_n),
      .srcPulse(start_reg),
      .dstClk(port_c_transmit_clock),
      .dstRst_n(rst_n),
      .dstPulse(txStart)
   );

   mii_port_pkg::tx_state_e txState_reg, txState_next;
   logic [AddrW-1:0] rdPtr_reg, rdPtr_next;
   logic [3:0] preCnt_reg, preCnt_next;
   logic half_reg, half_next;
   logic [3:0] txNib_reg, txNib_next;
   logic txValid_reg, txValid_next;
   logic txEnd_reg, txEnd_next;
   logic [7:0] curByte;

   // Frame store is stable while busy, so reading it here is safe
   assign curByte = mem_reg[rdPtr_reg];

   // Preamble, delimiter, then data low nibble first
   always_comb
   begin
      txState_next = txState_reg;
      rdPtr_next = rdPtr_reg;
      preCnt_next = preCnt_reg;
      half_next = half_reg;
      txNib_next = `MII_TX_IDLE;
      txValid_next = 1'b0;
      txEnd_next = 1'b0;
      case (txState_reg)
         mii_port_pkg::TX_IDLE:
         begin
            if (txStart && txEnable)
            begin
               txState_next = mii_port_pkg::TX_PREAMBLE;
               txNib_next = `MII_PREAMBLE_NIBBLE;
               txValid_next = 1'b1;
               preCnt_next = 4'h1;
            end
         end
         mii_port_pkg::TX_PREAMBLE:
         begin
            txValid_next = 1'b1;
            if (preCnt_reg == 4'(`MII_PREAMBLE_COUNT))
            begin
               txNib_next = `MII_SFD_NIBBLE;
               txState_next = mii_port_pkg::TX_DATA;
               rdPtr_next = '0;
               half_next = 1'b0;
            end
            else
            begin
               txNib_next = `MII_PREAMBLE_NIBBLE;
               preCnt_next = preCnt_reg + 4'h1;
            end
         end
         mii_port_pkg::TX_DATA:
         begin
            txValid_next = 1'b1;
            txNib_next = half_reg ? curByte[7:4] : curByte[3:0];
            half_next = ~half_reg;
            if (half_reg)
            begin
               rdPtr_next = rdPtr_reg + 1'b1;
               if (rdPtr_reg == len_reg)
               begin
                  txState_next = mii_port_pkg::TX_IDLE;
                  txEnd_next = 1'b1;
               end
            end
         end
         default:
            txState_next = mii_port_pkg::TX_IDLE;
      endcase
   end

   always_ff @(posedge port_c_transmit_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         txState_reg <= mii_port_pkg::TX_IDLE;
         rdPtr_reg <= '0;
         preCnt_reg <= 4'h0;
         half_reg <= 1'b0;
         txNib_reg <= `MII_TX_IDLE;
         txValid_reg <= 1'b0;
         txEnd_reg <= 1'b0;
      end
      else
      begin
         txState_reg <= txState_next;
         rdPtr_reg <= rdPtr_next;
         preCnt_reg <= preCnt_next;
         half_reg <= half_next;
         txNib_reg <= txNib_next;
         txValid_reg <= txValid_next;
         txEnd_reg <= txEnd_next;
      end
   end

   mii_toggle_sync endXfer
   (
      .srcClk(port_c_transmit_clock),
      .srcRst_n(rst_n),
      .srcPulse(txEnd_reg),
      .dstClk(clk),
      .dstRst_n(rst_n),
      .dstPulse(txEndSys)
   );

   // ---------------- Receive link domain
   logic [3:0] rxData_reg, rxData_next;
   logic rxDv_reg, rxDv_next;
   logic rxEvt_next;
   logic rxEnd_reg, rxEnd_next;
   logic [3:0] rxHold_reg, rxHold_next;

   // Pin capture, then accept only while valid; a disabled port drops all
   // The toggle flips on the same edge as the hold, so the next nibble cannot overwrite it first
   always_comb
   begin
      rxData_next = port_c_receive_nibble;
      rxDv_next = port_c_receive_valid;
      rxEvt_next = rxDv_reg && rxEnable;
      rxEnd_next = !rxDv_next && rxDv_reg && rxEnable;
      rxHold_next = rxEvt_next ? rxData_reg : rxHold_reg;
   end

   always_ff @(posedge port_c_receive_clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxData_reg <= 4'h0;
         rxDv_reg <= 1'b0;
         rxEnd_reg <= 1'b0;
         rxHold_reg <= 4'h0;
      end
      else
      begin
         rxData_reg <= rxData_next;
         rxDv_reg <= rxDv_next;
         rxEnd_reg <= rxEnd_next;
         rxHold_reg <= rxHold_next;
      end
   end

   mii_toggle_sync rxXfer
   (
      .srcClk(port_c_receive_clock),
      .srcRst_n(rst_n),
      .srcPulse(rxEvt_next),
      .dstClk(clk),
      .dstRst_n(rst_n),
      .dstPulse(rxPulseSys)
   );

   mii_toggle_sync rxEndXfer
   (
      .srcClk(port_c_receive_clock),
      .srcRst_n(rst_n),
      .srcPulse(rxEnd_reg),
      .dstClk(clk),
      .dstRst_n(rst_n),
      .dstPulse(rxEndSys)
   );

   // Held nibble is stable for several system cycles before the pulse
   logic rxValidOut_reg;
   logic [3:0] rxNibOut_reg;
   logic rxEndOut_reg;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rxValidOut_reg <= 1'b0;
         rxNibOut_reg <= 4'h0;
         rxEndOut_reg <= 1'b0;
      end
      else
      begin
         rxValidOut_reg <= rxPulseSys;
         rxNibOut_reg <= rxPulseSys ? rxHold_reg : rxNibOut_reg;
         rxEndOut_reg <= rxEndSys;
      end
   end

   // Outputs
   assign txLoadReady = ready_reg;
   assign txDone = txDone_reg;
   assign rxNibbleValid = rxValidOut_reg;
   assign rxNibble = rxNibOut_reg;
   assign rxFrameEnd = rxEndOut_reg;
   assign carrierSense = crs_reg;
   assign collision = col_reg;
   assign portEnabled = enable_reg;
   assign port_c_transmit_nibble = txNib_reg;
   assign port_c_transmit_valid = txValid_reg;

endmodule

// ---- hw/mii_sync_bit.sv ----
`timescale 1ns/100ps
`include "mii_port_consts.svh"

module mii_sync_bit
(
   // Destination clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Asynchronous level in, synchronised level out
   input wire logic asyncIn,
   output logic syncOut
);

   logic stage1_reg;
   logic stage2_reg;
   logic stage1_next;
   logic stage2_next;

   // First stage feeds only the second stage
   always_comb
   begin
      stage1_next = asyncIn;
      stage2_next = stage1_reg;
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         stage1_reg <= 1'b0;
         stage2_reg <= 1'b0;
      end
      else
      begin
         stage1_reg <= stage1_next;
         stage2_reg <= stage2_next;
      end
   end

   assign syncOut = stage2_reg;

endmodule

// ---- hw/mii_toggle_sync.sv ----
`timescale 1ns/100ps

module mii_toggle_sync
(
   // Source domain
   input wire logic srcClk,
   input wire logic srcRst_n,
   input wire logic srcPulse,
   // Destination domain
   input wire logic dstClk,
   input wire logic dstRst_n,
   output logic dstPulse
);

   logic toggle_reg;
   logic toggle_next;
   logic syncToggle;
   logic last_reg;
   logic last_next;
   logic pulse_reg;
   logic pulse_next;

   // Event becomes a level change, safe to carry across clocks
   always_comb
   begin
      toggle_next = toggle_reg ^ srcPulse;
   end

   always_ff @(posedge srcClk or negedge srcRst_n)
   begin
      if (!srcRst_n)
         toggle_reg <= 1'b0;
      else
         toggle_reg <= toggle_next;
   end

   mii_sync_bit togSync
   (
      .clk(dstClk),
      .rst_n(dstRst_n),
      .asyncIn(toggle_reg),
      .syncOut(syncToggle)
   );

   // Edge of the synchronised toggle gives one destination pulse
   always_comb
   begin
      last_next = syncToggle;
      pulse_next = syncToggle ^ last_reg;
   end

   always_ff @(posedge dstClk or negedge dstRst_n)
   begin
      if (!dstRst_n)
      begin
         last_reg <= 1'b0;
         pulse_reg <= 1'b0;
      end
      else
      begin
         last_reg <= last_next;
         pulse_reg <= pulse_next;
      end
   end

   assign dstPulse = pulse_reg;

endmodule
